/* timer8_consts.svh */
// Purpose: register offsets, field positions, reset values and divider counts
// Assumes: byte-wide registers on a plain address/strobe port
// Notes: channel index is the low two address bits of each group
`ifndef TIMER8_CONSTS_SVH
`define TIMER8_CONSTS_SVH

// register groups, one byte per channel, channel in addr[1:0]; match status is a single byte at 8'h10
`define T8_CTRL_BASE 8'h00
`define T8_COUNT_BASE 8'h04
`define T8_CMPA_BASE 8'h08
`define T8_CMPB_BASE 8'h0c
`define T8_MATCH_STAT 8'h10

// field positions in timer_control
`define T8_CLEAR_HI_POS 4
`define T8_CLEAR_LO_POS 3
`define T8_CLOCK_MSB_POS 2
`define T8_CLOCK_LSB_POS 0

// reset values
`define T8_CTRL_RESET 8'h00
`define T8_COUNT_RESET 8'h00
`define T8_CMP_RESET 8'hff

// system clock divisors for the three internal taps
`define T8_DIV_FAST 8
`define T8_DIV_MID 64
`define T8_DIV_SLOW 8192

`endif

/* timer8_pkg.sv */
// Purpose: shared types of the four-channel 8-bit timer
// Assumes: nothing beyond the constants header
// Notes: enumerations follow the control-field codes
package timer8_pkg;

  typedef enum logic [1:0] {
    CLEAR_NEVER = 2'h0,
    CLEAR_ON_MATCH_A = 2'h1,
    CLEAR_ON_MATCH_B = 2'h2,
    CLEAR_ON_EXT_RESET = 2'h3
  } clear_select_t;

  typedef enum logic [2:0] {
    CLOCK_OFF = 3'h0,
    CLOCK_DIV_FAST = 3'h1,
    CLOCK_DIV_MID = 3'h2,
    CLOCK_DIV_SLOW = 3'h3,
    CLOCK_PARTNER_OVF = 3'h4,
    CLOCK_EXT_RISE = 3'h5,
    CLOCK_EXT_FALL = 3'h6,
    CLOCK_EXT_BOTH = 3'h7
  } clock_source_t;

  typedef struct packed {
    clear_select_t clear_sel;
    clock_source_t clock_sel;
  } channel_cfg_t;

  typedef struct packed {
    logic fast;
    logic mid;
    logic slow;
  } prescale_ticks_t;

  typedef struct packed {
    logic clk_rise;
    logic clk_fall;
    logic rst_rise;
  } pin_events_t;

endpackage

/* timer8_prescaler.sv */
// Purpose: one-cycle enables at the falling edges of three divided clocks
// Assumes: divisors are powers of two, the slowest is the largest
// Notes: a tick marks the cycle where that divided clock would fall
`timescale 1ns/1ps
`default_nettype none
`include "timer8_consts.svh"
module timer8_prescaler #(
  parameter int DIV_FAST = `T8_DIV_FAST,
  parameter int DIV_MID = `T8_DIV_MID,
  parameter int DIV_SLOW = `T8_DIV_SLOW
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  output var timer8_pkg::prescale_ticks_t ticks_o
);
  localparam int W = $clog2(DIV_SLOW);

  logic [W-1:0] phase;
  logic [W-1:0] next_phase;
  timer8_pkg::prescale_ticks_t ticks;
  timer8_pkg::prescale_ticks_t next_ticks;

  // the tap falls when all its low phase bits wrap to zero
  always_comb begin
    next_phase = phase + W'(1);
    next_ticks.fast = (phase[$clog2(DIV_FAST)-1:0] == {$clog2(DIV_FAST){1'b1}});
    next_ticks.mid = (phase[$clog2(DIV_MID)-1:0] == {$clog2(DIV_MID){1'b1}});
    next_ticks.slow = (phase == {W{1'b1}});
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      phase <= '0;
      ticks <= '0;
    end else begin
      phase <= next_phase;
      ticks <= next_ticks;
    end
  end

  assign ticks_o = ticks;
endmodule
`default_nettype wire

/* timer8_channel.sv */
// Purpose: one 8-bit up-counter with clock-source and clear selection
// Assumes: all events are one-cycle pulses on core_clk_i
// Notes: software write wins over clear, clear wins over increment
`timescale 1ns/1ps
`default_nettype none
`include "timer8_consts.svh"
module timer8_channel #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire timer8_pkg::channel_cfg_t cfg_i,
  input wire timer8_pkg::prescale_ticks_t ticks_i,
  input wire timer8_pkg::pin_events_t pins_i,
  input wire logic partner_ovf_i,
  input wire logic [WIDTH-1:0] cmp_a_i,
  input wire logic [WIDTH-1:0] cmp_b_i,
  input wire logic wr_en_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic [WIDTH-1:0] count_o,
  output logic ovf_o,
  output logic match_a_o,
  output logic match_b_o
);
  logic [WIDTH-1:0] channel_counter;
  logic [WIDTH-1:0] next_channel_counter;
  logic ovf;
  logic next_ovf;
  logic count_en;
  logic clear_en;

  always_comb begin
    case (cfg_i.clock_sel)
      timer8_pkg::CLOCK_OFF: count_en = 1'b0;
      timer8_pkg::CLOCK_DIV_FAST: count_en = ticks_i.fast;
      timer8_pkg::CLOCK_DIV_MID: count_en = ticks_i.mid;
      timer8_pkg::CLOCK_DIV_SLOW: count_en = ticks_i.slow;
      timer8_pkg::CLOCK_PARTNER_OVF: count_en = partner_ovf_i;
      timer8_pkg::CLOCK_EXT_RISE: count_en = pins_i.clk_rise;
      timer8_pkg::CLOCK_EXT_FALL: count_en = pins_i.clk_fall;
      timer8_pkg::CLOCK_EXT_BOTH: count_en = pins_i.clk_rise | pins_i.clk_fall;
      default: count_en = 1'b0;
    endcase
    case (cfg_i.clear_sel)
      timer8_pkg::CLEAR_NEVER: clear_en = 1'b0;
      timer8_pkg::CLEAR_ON_MATCH_A: clear_en = (channel_counter == cmp_a_i);
      timer8_pkg::CLEAR_ON_MATCH_B: clear_en = (channel_counter == cmp_b_i);
      timer8_pkg::CLEAR_ON_EXT_RESET: clear_en = pins_i.rst_rise;
      default: clear_en = 1'b0;
    endcase
  end

  // overflow is registered so two partners on each other's overflow form no loop
  always_comb begin
    next_channel_counter = channel_counter;
    next_ovf = 1'b0;
    if (wr_en_i) begin
      next_channel_counter = wr_data_i;
    end else if (clear_en) begin
      next_channel_counter = '0;
    end else if (count_en) begin
      next_channel_counter = channel_counter + WIDTH'(1);
      next_ovf = (channel_counter == {WIDTH{1'b1}});
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      channel_counter <= WIDTH'(`T8_COUNT_RESET);
      ovf <= 1'b0;
    end else begin
      channel_counter <= next_channel_counter;
      ovf <= next_ovf;
    end
  end

  assign count_o = channel_counter;
  assign ovf_o = ovf;
  assign match_a_o = (channel_counter == cmp_a_i);
  assign match_b_o = (channel_counter == cmp_b_i);
endmodule
`default_nettype wire

/* timer8_clock_and_clear_select.sv */
// Purpose: four 8-bit counters in pairs with clock and clear selection
// Assumes: pins are synchronous to core_clk_i; byte register port
// Notes: read data stand only in the cycle after the read strobe
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "timer8_consts.svh"
module timer8_clock_and_clear_select #(
  parameter int WIDTH = 8,
  parameter int CHANNELS = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic ext_clk01_i,
  input wire logic ext_clk23_i,
  input wire logic ext_rst01_i,
  input wire logic ext_rst23_i,
  output logic [7:0] rd_data_o,
  output logic [CHANNELS-1:0] ovf_o
);
  logic [7:0] timer_control [CHANNELS];
  logic [7:0] next_timer_control [CHANNELS];
  logic [WIDTH-1:0] cmp_a [CHANNELS];
  logic [WIDTH-1:0] next_cmp_a [CHANNELS];
  logic [WIDTH-1:0] cmp_b [CHANNELS];
  logic [WIDTH-1:0] next_cmp_b [CHANNELS];
  logic [7:0] rd_data;
  logic [7:0] next_rd_data;

  logic [1:0] chan_sel;
  logic [7:0] group_base;
  logic [CHANNELS-1:0] count_wr;

  logic [WIDTH-1:0] count [CHANNELS];
  logic [CHANNELS-1:0] ovf;
  logic [CHANNELS-1:0] match_a;
  logic [CHANNELS-1:0] match_b;

  // pin sampling: current and previous samples of the four pins
  logic [3:0] pin_now;
  logic [3:0] pin_prev;
  logic [3:0] pin_raw;
  logic [3:0] next_pin_now;
  logic [3:0] next_pin_prev;
  timer8_pkg::pin_events_t pins01;
  timer8_pkg::pin_events_t pins23;
  timer8_pkg::prescale_ticks_t ticks;

  assign chan_sel = addr_i[1:0];
  assign group_base = {addr_i[7:2], 2'h0};
  assign pin_raw = {ext_rst23_i, ext_rst01_i, ext_clk23_i, ext_clk01_i};

  always_comb begin
    next_pin_now = pin_raw;
    next_pin_prev = pin_now;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_now <= 4'h0;
      pin_prev <= 4'h0;
    end else begin
      pin_now <= next_pin_now;
      pin_prev <= next_pin_prev;
    end
  end

  // edges from two successive samples, not from the raw pin
  always_comb begin
    pins01.clk_rise = pin_now[0] & ~pin_prev[0];
    pins01.clk_fall = ~pin_now[0] & pin_prev[0];
    pins01.rst_rise = pin_now[2] & ~pin_prev[2];
    pins23.clk_rise = pin_now[1] & ~pin_prev[1];
    pins23.clk_fall = ~pin_now[1] & pin_prev[1];
    pins23.rst_rise = pin_now[3] & ~pin_prev[3];
  end

  // register writes
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      next_timer_control[c] = timer_control[c];
      next_cmp_a[c] = cmp_a[c];
      next_cmp_b[c] = cmp_b[c];
      count_wr[c] = 1'b0;
    end
    if (wr_en_i) begin
      case (group_base)
        `T8_CTRL_BASE: next_timer_control[chan_sel] = wr_data_i;
        `T8_COUNT_BASE: count_wr[chan_sel] = 1'b1;
        `T8_CMPA_BASE: next_cmp_a[chan_sel] = wr_data_i[WIDTH-1:0];
        `T8_CMPB_BASE: next_cmp_b[chan_sel] = wr_data_i[WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // register reads, zero outside the read cycle and for unmapped addresses
  always_comb begin
    next_rd_data = 8'h00;
    if (rd_en_i) begin
      case (group_base)
        `T8_CTRL_BASE: next_rd_data = timer_control[chan_sel];
        `T8_COUNT_BASE: next_rd_data = count[chan_sel];
        `T8_CMPA_BASE: next_rd_data = cmp_a[chan_sel];
        `T8_CMPB_BASE: next_rd_data = cmp_b[chan_sel];
        `T8_MATCH_STAT: begin
          if (chan_sel == 2'h0) begin
            next_rd_data = {match_b, match_a};
          end
        end
        default: next_rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < CHANNELS; c++) begin
        timer_control[c] <= `T8_CTRL_RESET;
        cmp_a[c] <= `T8_CMP_RESET;
        cmp_b[c] <= `T8_CMP_RESET;
      end
      rd_data <= 8'h00;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        timer_control[c] <= next_timer_control[c];
        cmp_a[c] <= next_cmp_a[c];
        cmp_b[c] <= next_cmp_b[c];
      end
      rd_data <= next_rd_data;
    end
  end

  timer8_prescaler u_prescaler (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ticks_o(ticks)
  );

  // pins 01 serve channels 0 and 3, pins 23 serve channels 1 and 2
  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    timer8_pkg::channel_cfg_t cfg;
    assign cfg.clear_sel = timer8_pkg::clear_select_t'(
      timer_control[c][`T8_CLEAR_HI_POS:`T8_CLEAR_LO_POS]);
    assign cfg.clock_sel = timer8_pkg::clock_source_t'(
      timer_control[c][`T8_CLOCK_MSB_POS:`T8_CLOCK_LSB_POS]);

    timer8_channel #(
      .WIDTH(WIDTH)
    ) u_channel (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .cfg_i(cfg),
      .ticks_i(ticks),
      .pins_i((c == 0 || c == 3) ? pins01 : pins23),
      .partner_ovf_i(ovf[c ^ 1]),
      .cmp_a_i(cmp_a[c]),
      .cmp_b_i(cmp_b[c]),
      .wr_en_i(count_wr[c]),
      .wr_data_i(wr_data_i[WIDTH-1:0]),
      .count_o(count[c]),
      .ovf_o(ovf[c]),
      .match_a_o(match_a[c]),
      .match_b_o(match_b[c])
    );
  end

  assign rd_data_o = rd_data;
  assign ovf_o = ovf;
endmodule
`default_nettype wire

/* timer8_select_monitor.sv */
// Purpose: bus and overflow checks at the timer ports
// Assumes: byte map of the timer, four channels
// Notes: shadows counter writes too, but checks readback only of what software alone changes
`timescale 1ns/1ps
`default_nettype none
module timer8_select_monitor #(
  parameter int CHANNELS = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] rd_data_o,
  input wire logic [CHANNELS-1:0] ovf_o
);
  logic [7:0] regs [16];
  logic [7:0] exp_rd;
  logic [3:0] off_now, off_q, chain_now, chain_q, prt_q;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      off_now[i] = regs[i][2:0] == 3'h0;
      chain_now[i] = regs[i][2:0] == 3'h4;
    end
  end
  always_ff @(posedge core_clk_i) begin
    exp_rd <= regs[addr_i[3:0]];
    off_q <= off_now;
    chain_q <= chain_now;
    // partner overflow of each channel, as seen by that channel
    prt_q <= {ovf_o[2], ovf_o[3], ovf_o[0], ovf_o[1]};
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        regs[i] <= (i < 8) ? 8'h00 : 8'hff;
      end
    end else if (wr_en_i && addr_i < 8'h10) begin
      regs[addr_i[3:0]] <= wr_data_i;
    end
  end
  rd_idle_a: assert property (!$past(rd_en_i) |-> rd_data_o == 8'h00)
    else $error("read data outside slot");
  unmapped_rd_a: assert property (rd_en_i && addr_i > 8'h10 |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  ctrl_rd_a: assert property (rd_en_i && addr_i < 8'h04 |=> rd_data_o == exp_rd)
    else $error("control readback wrong");
  cmp_rd_a: assert property (rd_en_i && addr_i[7:3] == 5'h01 |=> rd_data_o == exp_rd)
    else $error("compare readback wrong");
  ovf_pulse_a: assert property (|ovf_o |=> (ovf_o & $past(ovf_o)) == '0)
    else $error("overflow longer than one cycle");
  idle_ovf_a: assert property ((ovf_o & off_now & off_q) == '0)
    else $error("stopped channel overflowed");
  chain_ovf_a: assert property ((ovf_o & chain_q & ~prt_q) == '0)
    else $error("chained overflow without partner");
  rst_quiet_a: assert property (disable iff (1'b0)
    rst_i |=> rd_data_o == 8'h00 && ovf_o == '0)
    else $error("outputs active in reset");
endmodule
bind timer8_clock_and_clear_select timer8_select_monitor #(.CHANNELS(CHANNELS)) u_mon (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .ovf_o(ovf_o));
`default_nettype wire

/* timer8_pin_source.sv */
// Purpose: external clock and reset pins of the timer
// Assumes: pins order {rst23, rst01, clk23, clk01}
// Notes: a pin moves only right after an edge
`timescale 1ns/1ps
`default_nettype none
module timer8_pin_source (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] flip_i,
  output logic [3:0] pins_o
);
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pins_o <= 4'h0;
    end else begin
      pins_o <= pins_o ^ flip_i;
    end
  end
endmodule
`default_nettype wire

/* tb_timer8_clock_and_clear_select.sv */
// Purpose: self-checking bench of the clock and clear selection
// Assumes: counting windows measured from counter write to stop write
// Notes: stopping by control write keeps the window exact
`timescale 1ns/1ps
`default_nettype none
module tb_timer8_clock_and_clear_select;
  typedef struct {logic [7:0] code; int win; int pulses; logic [7:0] exp;} row_t;
  logic core_clk_i, rst_i, wr_en_i, rd_en_i;
  logic [7:0] addr_i, wr_data_i, rd_data_o, got;
  logic [3:0] ovf_o, flip, pins;
  int err_total, n_checks;
  // partner row keeps channel 1 off, never on compare count
  row_t rows [8] = '{'{8'h00, 64, 3, 8'h00}, '{8'h01, 64, 3, 8'h08},
    '{8'h02, 64, 3, 8'h01}, '{8'h03, 8192, 0, 8'h01}, '{8'h04, 64, 3, 8'h00},
    '{8'h05, 64, 3, 8'h03}, '{8'h06, 64, 3, 8'h03}, '{8'h07, 64, 3, 8'h06}};
  logic [7:0] clr_exp [4] = '{8'h0a, 8'h03, 8'h03, 8'h02};
  timer8_clock_and_clear_select uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .ext_clk01_i(pins[0]), .ext_clk23_i(pins[1]), .ext_rst01_i(pins[2]),
    .ext_rst23_i(pins[3]), .rd_data_o(rd_data_o), .ovf_o(ovf_o));
  timer8_pin_source pin_src (.core_clk_i(core_clk_i), .rst_i(rst_i), .flip_i(flip),
    .pins_o(pins));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge core_clk_i);
    wr_en_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge core_clk_i);
    rd_en_i <= 1'b0;
    @(negedge core_clk_i);
    got = rd_data_o;
    n_checks++;
    if (got !== e) begin
      err_total++;
      $display("wrong value at %0t: addr %h got %h want %h", $time, a, got, e);
    end
    @(posedge core_clk_i);
  endtask
  task automatic chk_ovf(input logic [3:0] e);
    @(negedge core_clk_i);
    n_checks++;
    if (ovf_o !== e) begin
      err_total++;
      $display("wrong value at %0t: overflow %h want %h", $time, ovf_o, e);
    end
    @(posedge core_clk_i);
  endtask
  task automatic flip_pin(input logic [3:0] m, input int n);
    repeat (n) begin
      flip <= m;
      @(posedge core_clk_i);
      flip <= 4'h0;
      @(posedge core_clk_i);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  initial begin
    #1000000;
    err_total++;
    finish_test();
  end
  initial begin
    rst_i = 1'b1;
    wr_en_i = 1'b0;
    rd_en_i = 1'b0;
    addr_i = 8'h00;
    wr_data_i = 8'h00;
    flip = 4'h0;
    err_total = 0;
    n_checks = 0;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    chk(8'h0b, 8'hff);
    chk(8'h0f, 8'hff);
    chk(8'h13, 8'h00);
    foreach (rows[i]) begin
      wr(8'h00, rows[i].code);
      wr(8'h04, 8'h00);
      flip_pin(4'h1, 2 * rows[i].pulses);
      repeat (rows[i].win - 2 - 4 * rows[i].pulses) @(posedge core_clk_i);
      wr(8'h00, 8'h00);
      chk(8'h04, rows[i].exp);
    end
    wr(8'h08, 8'h07);
    wr(8'h0c, 8'h07);
    for (int c = 0; c < 4; c++) begin
      wr(8'h04, 8'h00);
      wr(8'h00, 8'(c * 8 + 5));
      flip_pin(4'h1, 16);
      if (c == 3) begin
        flip_pin(4'h4, 1);
      end
      flip_pin(4'h1, 4);
      wr(8'h00, 8'h00);
      chk(8'h04, clr_exp[c]);
    end
    wr(8'h01, 8'h04);
    wr(8'h02, 8'h04);
    wr(8'h04, 8'hff);
    wr(8'h07, 8'hff);
    wr(8'h00, 8'h05);
    wr(8'h03, 8'h05);
    flip_pin(4'h1, 1);
    @(posedge core_clk_i);
    chk_ovf(4'h9);
    chk_ovf(4'h0);
    flip_pin(4'h1, 1);
    chk(8'h04, 8'h00);
    chk(8'h05, 8'h01);
    chk(8'h06, 8'h01);
    chk(8'h01, 8'h04);
    wr(8'h09, 8'h01);
    wr(8'h0e, 8'h01);
    chk(8'h10, 8'h42);
    // mid-run reset must bring counters, controls and compares back
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    chk(8'h05, 8'h00);
    chk(8'h01, 8'h00);
    chk(8'h0e, 8'hff);
    // second pin pair: clock pin 23 counts, reset pin 23 clears
    wr(8'h01, 8'h1d);
    wr(8'h02, 8'h05);
    flip_pin(4'h2, 2);
    flip_pin(4'h8, 1);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h00);
    chk(8'h05, 8'h00);
    chk(8'h06, 8'h01);
    finish_test();
  end
endmodule
`default_nettype wire
